// >>> design/cnbt_pkg.sv
package cnbt_pkg;
   // register offsets
   localparam logic [7:0] OFS_STATUS   = 8'h22;
   localparam logic [7:0] OFS_IRQ      = 8'h23;
   localparam logic [7:0] OFS_ACODE    = 8'h24;
   localparam logic [7:0] OFS_AMASK    = 8'h25;
   localparam logic [7:0] OFS_BT0      = 8'h26;
   localparam logic [7:0] OFS_BT1      = 8'h27;
   localparam logic [7:0] OFS_CTRL     = 8'h20;
   localparam logic [7:0] OFS_CMD      = 8'h21;
   // irq flag positions
   localparam int IRQ_RX   = 0;
   localparam int IRQ_TX   = 1;
   localparam int IRQ_ERR  = 2;
   localparam int IRQ_OVR  = 3;
   localparam int IRQ_WAKE = 4;
   // control register positions
   localparam int CTL_RST_REQ = 0;
   localparam int CTL_RX_IE   = 1;
   localparam int CTL_TX_IE   = 2;
   localparam int CTL_ERR_IE  = 3;
   localparam int CTL_OVR_IE  = 4;
   // command register positions
   localparam int CMD_SLEEP   = 4;
   localparam int CMD_REL_RX  = 2;
   localparam int CMD_CLR_OVR = 3;
   // status register positions
   localparam int ST_RX_FULL  = 0;
   localparam int ST_OVR      = 1;
   localparam int ST_TX_ACC   = 2;
   localparam int ST_ERR_WARN = 6;
   localparam int ST_BUS_OFF  = 7;
   // field positions in timing registers
   localparam int BT0_SJW_LSB  = 6;
   localparam int BT1_TRIPLE_SAMPLE_SEL     = 7;
   localparam int BT1_TS2_LSB  = 4;
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h01;
   localparam logic [7:0] RST_BT0  = 8'h00;
   localparam logic [7:0] RST_BT1  = 8'h23;
   // error counter limits
   localparam logic [8:0] ERR_WARN_LIM = 9'h060;
   localparam logic [8:0] ERR_OFF_LIM  = 9'h100;
   typedef enum logic [1:0] {
      SEG_SYNC = 2'b00,
      SEG_ONE  = 2'b01,
      SEG_TWO  = 2'b10
   } cnbt_seg_t;
endpackage

// >>> design/cnbt_bit_timer.sv
`timescale 1ns/1ps
// time quantum prescaler and bit segment sequencer
module cnbt_bit_timer #(
   parameter int PW = 6
) (
   input  wire logic          core_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          run_i,
   input  wire logic [PW-1:0] prescale_i,
   input  wire logic [1:0]    jump_width_i,
   input  wire logic [3:0]    first_segment_i,
   input  wire logic [2:0]    second_segment_i,
   input  wire logic          triple_i,
   input  wire logic          rx_i,
   output logic               sample_o,
   output logic               rx_bit_o,
   output logic               tx_point_o
);
   logic [PW-1:0]       pre_q, pre_d;
   logic [4:0]          qc_q, qc_d;
   cnbt_pkg::cnbt_seg_t seg_q, seg_d;
   logic [1:0]          smp_q, smp_d;
   logic                rx_prev_q, rx_prev_d;
   logic                bit_q, bit_d;
   logic                spl_q, spl_d;
   logic                txp_q, txp_d;
   logic                tq;
   logic                edge_det;
   logic [4:0]          ts1_len, ts2_len, sjw_len;

   assign tq       = (pre_q == prescale_i);
   assign ts1_len  = {1'b0, first_segment_i} + 5'h01;
   assign ts2_len  = {2'b00, second_segment_i} + 5'h01;
   assign sjw_len  = {3'b000, jump_width_i} + 5'h01;
   assign edge_det = rx_i != rx_prev_q;
   assign sample_o   = spl_q;
   assign rx_bit_o   = bit_q;
   assign tx_point_o = txp_q;

   always_comb begin
      pre_d     = tq ? '0 : pre_q + 1'b1;
      qc_d      = qc_q;
      seg_d     = seg_q;
      smp_d     = smp_q;
      rx_prev_d = rx_i;
      bit_d     = bit_q;
      spl_d     = 1'b0;
      txp_d     = 1'b0;
      if (!run_i) begin
         pre_d = '0;
         qc_d  = 5'h00;
         seg_d = cnbt_pkg::SEG_SYNC;
      end else if (tq) begin
         // bit time = sync quantum + first segment + second segment
         case (seg_q)
            cnbt_pkg::SEG_SYNC: begin
               seg_d = cnbt_pkg::SEG_ONE;
               qc_d  = 5'h01;
            end
            cnbt_pkg::SEG_ONE: begin
               if (edge_det && qc_q < sjw_len) begin
                  qc_d = 5'h01;
               end else if (qc_q >= ts1_len) begin
                  seg_d = cnbt_pkg::SEG_TWO;
                  qc_d  = 5'h01;
               end else begin
                  qc_d = qc_q + 5'h01;
               end
               smp_d = {smp_q[0], rx_i};
               if (qc_q >= ts1_len) begin
                  spl_d = 1'b1;
                  if (triple_i) begin
                     bit_d = (smp_q[1] & smp_q[0]) | (smp_q[1] & rx_i) | (smp_q[0] & rx_i);
                  end else begin
                     bit_d = rx_i;
                  end
               end
            end
            cnbt_pkg::SEG_TWO: begin
               if (edge_det && (ts2_len - qc_q) < sjw_len) begin
                  seg_d = cnbt_pkg::SEG_ONE;
                  qc_d  = 5'h01;
                  txp_d = 1'b1;
               end else if (qc_q >= ts2_len) begin
                  seg_d = cnbt_pkg::SEG_SYNC;
                  qc_d  = 5'h00;
                  txp_d = 1'b1;
               end else begin
                  qc_d = qc_q + 5'h01;
               end
            end
            default: begin
               seg_d = cnbt_pkg::SEG_SYNC;
               qc_d  = 5'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pre_q     <= '0;
         qc_q      <= 5'h00;
         seg_q     <= cnbt_pkg::SEG_SYNC;
         smp_q     <= 2'h3;
         rx_prev_q <= 1'b1;
         bit_q     <= 1'b1;
         spl_q     <= 1'b0;
         txp_q     <= 1'b0;
      end else begin
         pre_q     <= pre_d;
         qc_q      <= qc_d;
         seg_q     <= seg_d;
         smp_q     <= smp_d;
         rx_prev_q <= rx_prev_d;
         bit_q     <= bit_d;
         spl_q     <= spl_d;
         txp_q     <= txp_d;
      end
   end

   AST_SAMPLE_ONE_CYCLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      sample_o |=> !sample_o) else $error("sample pulse longer than one cycle");
endmodule

// >>> design/cnbt_core.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - bus activity in sleep clears sleep bit, then sets wake flag
// - wake flag clears on irq register read or external reset
// - overrun sets overrun flag when overrun irq enabled
// - overrun, tx, rx flags clear on read or reset request
// - error or bus status change sets error flag when enabled
// - end of transmission sets tx flag if buffer accessible and enabled
// - new message sets rx flag together with rx buffer full
// - every message stored; only accepted ones signal the cpu
// - code compared with identifier bits 10..3, qualified by mask
// - mask 0 means must match, mask 1 means don't care
// - accepted message goes to free buffer, else overrun
// - resync jump width 1 to 4 quanta from 2-bit field
// - 6-bit prescaler sets the time quantum
// - sampling bit selects three samples or one per bit
// - bus sampled at sample point, third sample in triple mode
// - transmitter drives new bit at the transmit point
// - segment lengths are field value plus one
// - bit time is sync plus first plus second segment
// - transmit counter at 256 enters bus-off and sets reset request
// - error warning set when either counter reaches 96
module cnbt_core #(
   parameter int PW = 6
) (
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       bus_activity_i,
   input  wire logic       msg_done_i,
   input  wire logic [7:0] upper_identifier_i,
   input  wire logic       tx_end_i,
   input  wire logic       tx_buf_accessible_i,
   input  wire logic [8:0] rx_err_cnt_i,
   input  wire logic [8:0] tx_err_cnt_i,
   input  wire logic       rx_i,
   output logic            irq_o,
   output logic            sample_o,
   output logic            rx_bit_o,
   output logic            tx_point_o,
   output logic            store_o,
   output logic            store_buf_o,
   output logic            bus_off_o
);
   logic [7:0] id_accept_code_q, id_accept_code_d;
   logic [7:0] id_accept_mask_q, id_accept_mask_d;
   logic [7:0] bit_timing_prescale_q, bit_timing_prescale_d;
   logic [7:0] bit_timing_segments_q, bit_timing_segments_d;
   logic [7:0] control_reg_q, control_reg_d;
   logic       sleep_q, sleep_d;
   logic [4:0] irq_flags_q, irq_flags_d;
   logic [1:0] buf_full_q, buf_full_d;
   logic       cur_buf_q, cur_buf_d;
   logic       ovr_q, ovr_d;
   logic       warn_q, warn_d;
   logic       off_q, off_d;
   logic [7:0] rdata_q, rdata_d;
   logic       irq_q, irq_d;
   logic       store_q, store_d;
   logic       store_buf_q, store_buf_d;
   logic       wake_pend_q, wake_pend_d;
   logic       rst_req, cfg_open, rd_irq, accept, no_free, overrun_ev;
   logic [7:0] hit;
   logic [7:0] status_reg;

   assign rst_req  = control_reg_q[cnbt_pkg::CTL_RST_REQ];
   assign cfg_open = rst_req;
   assign rd_irq   = rd_i && addr_i == cnbt_pkg::OFS_IRQ;

   // per-bit acceptance compare
   for (genvar g = 0; g < 8; g++) begin : g_flt
      assign hit[g] = id_accept_mask_q[g] | (id_accept_code_q[g] == upper_identifier_i[g]);
   end
   assign accept     = &hit;
   assign no_free    = &buf_full_q;
   assign overrun_ev = msg_done_i && accept && no_free;

   assign status_reg = {off_q, warn_q, 3'b000, tx_buf_accessible_i, ovr_q, buf_full_q[0]};

   always_comb begin
      id_accept_code_d      = id_accept_code_q;
      id_accept_mask_d      = id_accept_mask_q;
      bit_timing_prescale_d = bit_timing_prescale_q;
      bit_timing_segments_d = bit_timing_segments_q;
      control_reg_d         = control_reg_q;
      sleep_d               = sleep_q;
      buf_full_d            = buf_full_q;
      cur_buf_d             = cur_buf_q;
      ovr_d                 = ovr_q;
      store_d               = 1'b0;
      store_buf_d           = store_buf_q;
      wake_pend_d           = 1'b0;
      rdata_d               = 8'h00;
      if (wr_i) begin
         case (addr_i)
            cnbt_pkg::OFS_CTRL: control_reg_d = wdata_i;
            cnbt_pkg::OFS_CMD: begin
               sleep_d = wdata_i[cnbt_pkg::CMD_SLEEP];
               if (wdata_i[cnbt_pkg::CMD_CLR_OVR]) begin
                  ovr_d = 1'b0;
               end
               if (wdata_i[cnbt_pkg::CMD_REL_RX]) begin
                  buf_full_d = {1'b0, buf_full_q[1]};
               end
            end
            cnbt_pkg::OFS_ACODE: if (cfg_open) id_accept_code_d = wdata_i;
            cnbt_pkg::OFS_AMASK: if (cfg_open) id_accept_mask_d = wdata_i;
            cnbt_pkg::OFS_BT0:   if (cfg_open) bit_timing_prescale_d = wdata_i;
            cnbt_pkg::OFS_BT1:   if (cfg_open) bit_timing_segments_d = wdata_i;
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            cnbt_pkg::OFS_CTRL:   rdata_d = control_reg_q;
            cnbt_pkg::OFS_CMD:    rdata_d = {3'b000, sleep_q, 4'h0};
            cnbt_pkg::OFS_STATUS: rdata_d = status_reg;
            cnbt_pkg::OFS_IRQ:    rdata_d = {3'b000, irq_flags_q};
            cnbt_pkg::OFS_ACODE:  rdata_d = cfg_open ? id_accept_code_q : 8'h00;
            cnbt_pkg::OFS_AMASK:  rdata_d = cfg_open ? id_accept_mask_q : 8'h00;
            cnbt_pkg::OFS_BT0:    rdata_d = cfg_open ? bit_timing_prescale_q : 8'h00;
            cnbt_pkg::OFS_BT1:    rdata_d = cfg_open ? bit_timing_segments_q : 8'h00;
            default:              rdata_d = 8'h00;
         endcase
      end
      // wake: clear sleep first, flag follows a cycle later
      if (sleep_q && bus_activity_i) begin
         sleep_d     = 1'b0;
         wake_pend_d = 1'b1;
      end
      if (msg_done_i) begin
         store_d     = 1'b1;
         store_buf_d = cur_buf_q;
         if (accept && !no_free) begin
            // fill the cpu side slot first so a release hands messages over in order
            if (buf_full_d[0]) begin
               buf_full_d[1] = 1'b1;
            end else begin
               buf_full_d[0] = 1'b1;
            end
         end
      end
      cur_buf_d = buf_full_d[0];
      if (overrun_ev) begin
         ovr_d = 1'b1;
      end
      warn_d = (rx_err_cnt_i >= cnbt_pkg::ERR_WARN_LIM) ||
               (tx_err_cnt_i >= cnbt_pkg::ERR_WARN_LIM);
      off_d  = off_q;
      if (tx_err_cnt_i >= cnbt_pkg::ERR_OFF_LIM) begin
         off_d                                = 1'b1;
         control_reg_d[cnbt_pkg::CTL_RST_REQ] = 1'b1;
      end else if (!rst_req && tx_err_cnt_i == 9'h000) begin
         off_d = 1'b0;
      end
   end

   // flags: set wins over read clear
   always_comb begin
      irq_flags_d = irq_flags_q;
      if (rd_irq) begin
         irq_flags_d = 5'h00;
      end
      if (rst_req) begin
         irq_flags_d[cnbt_pkg::IRQ_OVR] = 1'b0;
         irq_flags_d[cnbt_pkg::IRQ_TX]  = 1'b0;
         irq_flags_d[cnbt_pkg::IRQ_RX]  = 1'b0;
      end
      if (wake_pend_q) begin
         irq_flags_d[cnbt_pkg::IRQ_WAKE] = 1'b1;
      end
      if (overrun_ev && control_reg_q[cnbt_pkg::CTL_OVR_IE]) begin
         irq_flags_d[cnbt_pkg::IRQ_OVR] = 1'b1;
      end
      if (control_reg_q[cnbt_pkg::CTL_ERR_IE] && (warn_d != warn_q || off_d != off_q)) begin
         irq_flags_d[cnbt_pkg::IRQ_ERR] = 1'b1;
      end
      if (tx_end_i && tx_buf_accessible_i && control_reg_q[cnbt_pkg::CTL_TX_IE]) begin
         irq_flags_d[cnbt_pkg::IRQ_TX] = 1'b1;
      end
      if (msg_done_i && accept && !no_free && control_reg_q[cnbt_pkg::CTL_RX_IE]) begin
         irq_flags_d[cnbt_pkg::IRQ_RX] = 1'b1;
      end
      irq_d = |irq_flags_d;
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         id_accept_code_q      <= 8'h00;
         id_accept_mask_q      <= 8'hFF;
         bit_timing_prescale_q <= cnbt_pkg::RST_BT0;
         bit_timing_segments_q <= cnbt_pkg::RST_BT1;
         control_reg_q         <= cnbt_pkg::RST_CTRL;
         sleep_q               <= 1'b0;
         irq_flags_q           <= 5'h00;
         buf_full_q            <= 2'b00;
         cur_buf_q             <= 1'b0;
         ovr_q                 <= 1'b0;
         warn_q                <= 1'b0;
         off_q                 <= 1'b0;
         rdata_q               <= 8'h00;
         irq_q                 <= 1'b0;
         store_q               <= 1'b0;
         store_buf_q           <= 1'b0;
         wake_pend_q           <= 1'b0;
      end else begin
         id_accept_code_q      <= id_accept_code_d;
         id_accept_mask_q      <= id_accept_mask_d;
         bit_timing_prescale_q <= bit_timing_prescale_d;
         bit_timing_segments_q <= bit_timing_segments_d;
         control_reg_q         <= control_reg_d;
         sleep_q               <= sleep_d;
         irq_flags_q           <= irq_flags_d;
         buf_full_q            <= buf_full_d;
         cur_buf_q             <= cur_buf_d;
         ovr_q                 <= ovr_d;
         warn_q                <= warn_d;
         off_q                 <= off_d;
         rdata_q               <= rdata_d;
         irq_q                 <= irq_d;
         store_q               <= store_d;
         store_buf_q           <= store_buf_d;
         wake_pend_q           <= wake_pend_d;
      end
   end

   assign rdata_o     = rdata_q;
   assign irq_o       = irq_q;
   assign store_o     = store_q;
   assign store_buf_o = store_buf_q;
   assign bus_off_o   = off_q;

   cnbt_bit_timer #(
      .PW(PW)
   ) u_timer (
      .core_clk_i      (core_clk_i),
      .nrst_i          (nrst_i),
      .run_i           (!rst_req),
      .prescale_i      (bit_timing_prescale_q[PW-1:0]),
      .jump_width_i    (bit_timing_prescale_q[cnbt_pkg::BT0_SJW_LSB +: 2]),
      .first_segment_i (bit_timing_segments_q[3:0]),
      .second_segment_i(bit_timing_segments_q[cnbt_pkg::BT1_TS2_LSB +: 3]),
      .triple_i        (bit_timing_segments_q[cnbt_pkg::BT1_TRIPLE_SAMPLE_SEL]),
      .rx_i            (rx_i),
      .sample_o        (sample_o),
      .rx_bit_o        (rx_bit_o),
      .tx_point_o      (tx_point_o)
   );

   AST_WAKE_ORDER: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (sleep_q && bus_activity_i) |=> !sleep_q ##1 irq_flags_q[cnbt_pkg::IRQ_WAKE])
      else $error("wake flag not set after sleep clear");
   AST_READ_CLEARS_WAKE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (rd_irq && !wake_pend_q) |=> !irq_flags_q[cnbt_pkg::IRQ_WAKE])
      else $error("wake flag survived read");
   AST_OVR_SET: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (overrun_ev && control_reg_q[cnbt_pkg::CTL_OVR_IE]) |=> irq_flags_q[cnbt_pkg::IRQ_OVR])
      else $error("overrun flag not set");
   AST_RR_CLEARS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (rst_req && !overrun_ev && !msg_done_i && !tx_end_i)
      |=> (irq_flags_q[1:0] == 2'b00 && !irq_flags_q[cnbt_pkg::IRQ_OVR]))
      else $error("rx/tx/overrun flags set under reset request");
   AST_READ_CLEARS_TX: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (rd_irq && !tx_end_i) |=> !irq_flags_q[cnbt_pkg::IRQ_TX])
      else $error("tx flag survived read");
   AST_ERR_SET: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (control_reg_q[cnbt_pkg::CTL_ERR_IE] && (warn_d != warn_q || off_d != off_q))
      |=> irq_flags_q[cnbt_pkg::IRQ_ERR])
      else $error("error flag not set on status change");
   AST_TX_GATE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (!irq_flags_q[cnbt_pkg::IRQ_TX] && !tx_buf_accessible_i) |=> !irq_flags_q[cnbt_pkg::IRQ_TX])
      else $error("tx flag without accessible buffer");
   AST_RX_WITH_FULL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $rose(irq_flags_q[cnbt_pkg::IRQ_RX]) |-> |buf_full_q)
      else $error("rx flag without full buffer");
   AST_RX_SET: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (msg_done_i && accept && !no_free && control_reg_q[cnbt_pkg::CTL_RX_IE])
      |=> (irq_flags_q[cnbt_pkg::IRQ_RX] && buf_full_q[0]))
      else $error("rx flag and buffer full not set together");
   AST_STORE_EVERY: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      msg_done_i |=> store_o)
      else $error("message not stored");
   AST_FILTER_REJECT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (msg_done_i && !accept) |=> $stable(buf_full_q) || $past(wr_i))
      else $error("rejected message claimed buffer");
   AST_CFG_LOCKED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (wr_i && !cfg_open && addr_i == cnbt_pkg::OFS_ACODE) |=> $stable(id_accept_code_q))
      else $error("acceptance code written outside reset request");
   AST_TX_POINT_PULSE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      tx_point_o |=> !tx_point_o)
      else $error("transmit point pulse longer than one cycle");
   AST_BUS_OFF: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (tx_err_cnt_i >= cnbt_pkg::ERR_OFF_LIM) |=> off_q && rst_req)
      else $error("bus-off not entered");
   AST_WARN: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (rx_err_cnt_i >= cnbt_pkg::ERR_WARN_LIM) |=> warn_q)
      else $error("warning status missing");
   AST_IRQ_OUT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      ##1 (irq_o == |irq_flags_q))
      else $error("irq output does not follow flags");

   COV_WAKE: cover property (@(posedge core_clk_i) irq_flags_q[cnbt_pkg::IRQ_WAKE]);
   COV_ACCEPT: cover property (@(posedge core_clk_i) msg_done_i && accept);
   COV_OVERRUN: cover property (@(posedge core_clk_i) overrun_ev);
   COV_SAMPLE: cover property (@(posedge core_clk_i) sample_o);
endmodule

// >>> test/cnbt_bus_node.sv
`timescale 1ns/1ps
// far node: dominant frame of len_i cycles; the bus floats back to recessive when idle
module cnbt_bus_node (
   input  wire logic        core_clk_i,
   input  wire logic        send_i,
   input  wire logic [15:0] len_i,
   output logic             rx_o
);
   logic [15:0] left_q = 16'h0000;
   always_ff @(posedge core_clk_i) begin
      if (send_i) begin
         left_q <= len_i;
      end else if (left_q != 16'h0000) begin
         left_q <= left_q - 16'h0001;
      end
   end
   assign rx_o = (left_q == 16'h0000);
endmodule

// >>> test/test_can_irq_filter_bit_timing.sv
`timescale 1ns/1ps
module test_can_irq_filter_bit_timing;
   logic        core_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, upper_identifier_i = 8'h00;
   logic        wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, send = 1'b0;
   logic        bus_activity_i = 1'b0, msg_done_i = 1'b0;
   logic        tx_end_i = 1'b0, tx_buf_accessible_i = 1'b0;
   logic [8:0]  rx_err_cnt_i = 9'h000, tx_err_cnt_i = 9'h000;
   logic [7:0]  rdata_o, id;
   logic        rx_i, irq_o, sample_o, rx_bit_o, tx_point_o, store_o, store_buf_o, bus_off_o;
   logic [7:0]  exp_q[$];
   logic [31:0] rnd = 32'h00000E11;
   logic [7:0]  ra[7] = '{8'h20, 8'h24, 8'h25, 8'h26, 8'h27, 8'h23, 8'h30};
   logic [7:0]  rv[7] = '{8'h01, 8'h00, 8'hFF, 8'h00, 8'h23, 8'h00, 8'h00};
   logic [7:0]  ids[4] = '{8'hA5, 8'hAF, 8'h25, 8'hB5};
   int          n_fail = 0, n_tests = 0, p1, p2;

   cnbt_core dut (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .bus_activity_i, .msg_done_i, .upper_identifier_i, .tx_end_i, .tx_buf_accessible_i,
      .rx_err_cnt_i, .tx_err_cnt_i, .rx_i, .irq_o, .sample_o, .rx_bit_o, .tx_point_o,
      .store_o, .store_buf_o, .bus_off_o);
   cnbt_bus_node node (.core_clk_i, .send_i(send), .len_i(16'h0190), .rx_o(rx_i));

   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   // expected read data is queued here and compared by the monitor below
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(e);
      @(posedge core_clk_i);
      rd_i <= 1'b0;
   endtask
   always @(posedge core_clk_i) rd_d <= rd_i;
   always @(negedge core_clk_i) begin
      if (rd_d) chk("rdata", rdata_o, exp_q.pop_front());
   end
   task automatic pmsg(input logic [7:0] i, input logic sb);
      @(posedge core_clk_i);
      msg_done_i <= 1'b1;
      upper_identifier_i <= i;
      @(posedge core_clk_i);
      msg_done_i <= 1'b0;
      #1 chk("store", {7'h00, store_o}, 8'h01);
      chk("store buf", {7'h00, store_buf_o}, {7'h00, sb});
   endtask
   task automatic settle();
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic gap(output int p);
      p = 0;
      do begin
         @(negedge core_clk_i);
         p++;
      end while (sample_o !== 1'b1 && p < 3000);
   endtask
   task automatic pulse_tx();
      @(posedge core_clk_i);
      tx_end_i <= 1'b1;
      @(posedge core_clk_i);
      tx_end_i <= 1'b0;
      settle();
   endtask

   initial begin
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      for (logic [7:0] a = 8'h24; a <= 8'h27; a++) begin
         rnd = lfsr(rnd);
         wr(a, rnd[7:0]);
         rd(a, rnd[7:0]);
      end
      wr(cnbt_pkg::OFS_ACODE, 8'hA5);
      wr(cnbt_pkg::OFS_AMASK, 8'h0F);
      wr(cnbt_pkg::OFS_BT0, 8'h00);
      wr(cnbt_pkg::OFS_BT1, 8'h12);
      wr(cnbt_pkg::OFS_CTRL, 8'h1E);
      wr(cnbt_pkg::OFS_ACODE, 8'h00);
      rd(cnbt_pkg::OFS_ACODE, 8'h00);
      gap(p1);
      gap(p1);
      wr(cnbt_pkg::OFS_CTRL, 8'h01);
      rd(cnbt_pkg::OFS_ACODE, 8'hA5);
      wr(cnbt_pkg::OFS_BT1, 8'h17);
      wr(cnbt_pkg::OFS_CTRL, 8'h1E);
      gap(p2);
      gap(p2);
      chk("bit time", 8'((p1 > 0 && p1 % 6 == 0 && p2 * 6 == p1 * 11) ? 1 : 0), 8'h01);
      p1 = 0;
      do begin
         @(negedge core_clk_i);
         p1++;
      end while (tx_point_o !== 1'b1 && p1 < 100);
      chk("tx point", 8'(p1), 8'h02);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         id = (i < 4) ? ids[i] : rnd[7:0];
         pmsg(id, 1'b0);
         settle();
         chk("irq", {7'h00, irq_o}, {7'h00, ((id ^ 8'hA5) & 8'hF0) == 8'h00});
         rd(cnbt_pkg::OFS_IRQ, {7'h00, ((id ^ 8'hA5) & 8'hF0) == 8'h00});
         wr(cnbt_pkg::OFS_CMD, 8'h04);
      end
      pmsg(8'hA5, 1'b0);
      pmsg(8'hA5, 1'b1);
      pmsg(8'hA5, 1'b1);
      settle();
      rd(cnbt_pkg::OFS_IRQ, 8'h09);
      pmsg(8'hA5, 1'b1);
      settle();
      wr(cnbt_pkg::OFS_CTRL, 8'h01);
      rd(cnbt_pkg::OFS_IRQ, 8'h00);
      wr(cnbt_pkg::OFS_CMD, 8'h0C);
      wr(cnbt_pkg::OFS_CTRL, 8'h1E);
      tx_buf_accessible_i <= 1'b1;
      pulse_tx();
      rd(cnbt_pkg::OFS_IRQ, 8'h02);
      tx_buf_accessible_i <= 1'b0;
      pulse_tx();
      rd(cnbt_pkg::OFS_IRQ, 8'h00);
      rx_err_cnt_i <= 9'h05F;
      settle();
      rd(cnbt_pkg::OFS_IRQ, 8'h00);
      rx_err_cnt_i <= 9'h060;
      settle();
      rd(cnbt_pkg::OFS_IRQ, 8'h04);
      tx_err_cnt_i <= 9'h100;
      settle();
      chk("bus off", {7'h00, bus_off_o}, 8'h01);
      rd(cnbt_pkg::OFS_CTRL, 8'h1F);
      rd(cnbt_pkg::OFS_IRQ, 8'h04);
      tx_err_cnt_i <= 9'h000;
      rx_err_cnt_i <= 9'h000;
      wr(cnbt_pkg::OFS_CTRL, 8'h1E);
      settle();
      chk("bus on", {7'h00, bus_off_o}, 8'h00);
      rd(cnbt_pkg::OFS_IRQ, 8'h04);
      wr(cnbt_pkg::OFS_CMD, 8'h10);
      settle();
      bus_activity_i <= 1'b1;
      settle();
      bus_activity_i <= 1'b0;
      settle();
      rd(cnbt_pkg::OFS_IRQ, 8'h10);
      rd(cnbt_pkg::OFS_IRQ, 8'h00);
      wr(cnbt_pkg::OFS_CTRL, 8'h01);
      wr(cnbt_pkg::OFS_BT1, 8'hA3);
      wr(cnbt_pkg::OFS_CTRL, 8'h1E);
      send <= 1'b1;
      @(posedge core_clk_i);
      send <= 1'b0;
      repeat (250) @(posedge core_clk_i);
      chk("rx bit", {7'h00, rx_bit_o}, 8'h00);
      repeat (300) @(posedge core_clk_i);
      chk("rx bit", {7'h00, rx_bit_o}, 8'h01);
      settle();
      wrap_up();
   end

   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end
endmodule
